// >>> dcmg_clk_src.sv
`timescale 1ns/1ps
`default_nettype none
module dcmg_clk_src #(
    parameter int HALF_SAMPLE = 20,
    parameter int HALF_REF = 80
) (
    // Divided clock back from the device
    input wire logic rateClkIn,
    // Clocks towards the device
    output logic sampleClk,
    output logic refClk
);
    int words = 0;
    // Odd offsets keep edges off the system clock edges
    initial
    begin
        sampleClk = 1'b0;
        #1;
        forever #(HALF_SAMPLE) sampleClk = ~sampleClk;
    end
    initial
    begin
        refClk = 1'b0;
        #3;
        forever #(HALF_REF) refClk = ~refClk;
    end
    // Data source clocked from the divided clock, so no phase strobe is needed
    always @(posedge rateClkIn) words <= words + 1;
endmodule
`default_nettype wire

// >>> dcmg_clock_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "dcmg_regs.vh"

module dcmg_clock_gen (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // Clock pins
    input wire pllSupplyStrap,
    input wire sampleRateClockIn,
    input wire dataRateClockIn,
    output wire lockOrRateClockOut,
    output wire [31:0] loopFilterNode,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

// Low-bit mask for a divide code: 0 -> none, 3 -> three ones
function [3:0] lowMask;
    input [1:0] code;
    begin
        case (code)
            2'h0: lowMask = 4'h0;
            2'h1: lowMask = 4'h1;
            2'h2: lowMask = 4'h3;
            default: lowMask = 4'h7;
        endcase
    end
endfunction

function [1:0] modeOf;
    input strap;
    input dual;
    begin
        if (strap)
            modeOf = `DCMG_MODE_PLL;
        else if (dual)
            modeOf = `DCMG_MODE_DUAL;
        else
            modeOf = `DCMG_MODE_EXT;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

wire [2:0] pinSync;
wire strapSync;
wire sampleSync;
wire refSync;
reg sampleDly_r;
reg refDly_r;

dcmg_sync #(
    .WIDTH(3)
) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .asyncIn({pllSupplyStrap, sampleRateClockIn, dataRateClockIn}),
    .syncOut(pinSync)
);

assign strapSync = pinSync[2];
assign sampleSync = pinSync[1];
assign refSync = pinSync[0];

always @(posedge clk_sys)
begin
    if (sys_rst)
    begin
        sampleDly_r <= 1'b0;
        refDly_r <= 1'b0;
    end
    else
    begin
        sampleDly_r <= sampleSync;
        refDly_r <= refSync;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Control register and mode

reg [4:0] ctrl_r;
wire dualClk;
wire [1:0] ratioSel;
wire [1:0] vcoDiv;
wire [1:0] mode;
wire pllMode;

assign dualClk = ctrl_r[`DCMG_CTRL_DUAL_BIT];
assign ratioSel = ctrl_r[`DCMG_CTRL_SEL_LSB +: 2];
assign vcoDiv = ctrl_r[`DCMG_CTRL_DIV_LSB +: 2];
assign mode = modeOf(strapSync, dualClk);
assign pllMode = (mode == `DCMG_MODE_PLL);

////////////////////////////////////////////////////////////////////////////////
// Digital VCO and prescaler, held cleared outside PLL mode

reg [31:0] vcoAcc_r;
reg [31:0] vcoIncr_r;
reg [2:0] preCnt_r;
wire [32:0] vcoSum;
wire vcoTick;
wire preTick;

assign vcoSum = {1'b0, vcoAcc_r} + {1'b0, vcoIncr_r};
assign vcoTick = pllMode && vcoSum[32];
// Prescale field only matters with the PLL running
assign preTick = vcoTick && (({1'b0, preCnt_r} & lowMask(vcoDiv)) == lowMask(vcoDiv));

always @(posedge clk_sys)
begin
    if (sys_rst || !pllMode)
    begin
        vcoAcc_r <= 32'h0000_0000;
        preCnt_r <= 3'h0;
    end
    else
    begin
        vcoAcc_r <= vcoSum[31:0];
        if (vcoTick)
            preCnt_r <= preCnt_r + 3'h1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sample clock and divider chain

reg [3:0] divCnt_r;
wire sampleTick;
wire fbEdge;
wire refEdge;

// Sample pin ignored in PLL mode; prescaler output used instead
assign sampleTick = pllMode ? preTick : (sampleSync && !sampleDly_r);
// Chosen bit rises when its lower bits are all ones and it is clear
assign fbEdge = sampleTick && ((divCnt_r & lowMask(ratioSel)) == lowMask(ratioSel)) &&
                !divCnt_r[ratioSel];
assign refEdge = pllMode && refSync && !refDly_r;

always @(posedge clk_sys)
begin
    if (sys_rst)
        divCnt_r <= 4'h0;
    else if (sampleTick)
        divCnt_r <= divCnt_r + 4'h1;
end

////////////////////////////////////////////////////////////////////////////////
// Detector and loop integrator

wire pumpUp;
wire pumpDown;
wire pllLocked;

dcmg_pfd u_pfd (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .enable(pllMode),
    .refEdge(refEdge),
    .fbEdge(fbEdge),
    .pumpUp(pumpUp),
    .pumpDown(pumpDown),
    .locked(pllLocked)
);

// Clamped so the increment never wraps or stalls the VCO
always @(posedge clk_sys)
begin
    if (sys_rst || !pllMode)
        vcoIncr_r <= `DCMG_VCO_INCR_RST;
    else if (pumpUp && vcoIncr_r < `DCMG_VCO_INCR_MAX)
        vcoIncr_r <= vcoIncr_r + `DCMG_VCO_GAIN;
    else if (pumpDown && vcoIncr_r > `DCMG_VCO_GAIN)
        vcoIncr_r <= vcoIncr_r - `DCMG_VCO_GAIN;
end

assign loopFilterNode = vcoIncr_r;

////////////////////////////////////////////////////////////////////////////////
// Lock or rate clock pin

reg lockOut_r;

always @(posedge clk_sys)
begin
    if (sys_rst)
        lockOut_r <= 1'b0;
    else
    begin
        case (mode)
            `DCMG_MODE_EXT: lockOut_r <= divCnt_r[ratioSel];
            `DCMG_MODE_PLL: lockOut_r <= pllLocked;
            default: lockOut_r <= 1'b0;
        endcase
    end
end

assign lockOrRateClockOut = lockOut_r;

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave

reg awReady_r;
reg awHeld_r;
reg [3:0] awAddr_r;
reg wReady_r;
reg wHeld_r;
reg [31:0] wData_r;
reg [3:0] wStrb_r;
reg bValid_r;
reg [1:0] bResp_r;
reg arReady_r;
reg rValid_r;
reg [31:0] rData_r;
reg [1:0] rResp_r;
wire doWrite;

assign doWrite = awHeld_r && wHeld_r && !bValid_r;

always @(posedge clk_sys)
begin
    if (sys_rst)
    begin
        awReady_r <= 1'b1;
        awHeld_r <= 1'b0;
        awAddr_r <= 4'h0;
        wReady_r <= 1'b1;
        wHeld_r <= 1'b0;
        wData_r <= 32'h0000_0000;
        wStrb_r <= 4'h0;
        bValid_r <= 1'b0;
        bResp_r <= `DCMG_RESP_OKAY;
        ctrl_r <= `DCMG_CTRL_RST;
    end
    else
    begin
        if (awReady_r && s_axi_awvalid)
        begin
            awReady_r <= 1'b0;
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
        end
        if (wReady_r && s_axi_wvalid)
        begin
            wReady_r <= 1'b0;
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
        end
        if (doWrite)
        begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awReady_r <= 1'b1;
            wReady_r <= 1'b1;
            bValid_r <= 1'b1;
            bResp_r <= `DCMG_RESP_OKAY;
            // Read-only words take the write silently
            if ({awAddr_r[3:2], 2'b00} == `DCMG_ADDR_CTRL)
            begin
                if (wStrb_r[0])
                    ctrl_r <= wData_r[4:0];
            end
            else if ({awAddr_r[3:2], 2'b00} != `DCMG_ADDR_STATUS &&
                     {awAddr_r[3:2], 2'b00} != `DCMG_ADDR_VCO)
                bResp_r <= `DCMG_RESP_SLVERR;
        end
        else if (bValid_r && s_axi_bready)
            bValid_r <= 1'b0;
    end
end

always @(posedge clk_sys)
begin
    if (sys_rst)
    begin
        arReady_r <= 1'b1;
        rValid_r <= 1'b0;
        rData_r <= 32'h0000_0000;
        rResp_r <= `DCMG_RESP_OKAY;
    end
    else if (arReady_r && s_axi_arvalid)
    begin
        arReady_r <= 1'b0;
        rValid_r <= 1'b1;
        rResp_r <= `DCMG_RESP_OKAY;
        rData_r <= 32'h0000_0000;
        case ({s_axi_araddr[3:2], 2'b00})
            `DCMG_ADDR_CTRL: rData_r <= {27'h0, ctrl_r};
            `DCMG_ADDR_STATUS:
            begin
                rData_r[`DCMG_STAT_MODE_LSB +: 2] <= mode;
                rData_r[`DCMG_STAT_LOCK_BIT] <= pllLocked;
                rData_r[`DCMG_STAT_STRAP_BIT] <= strapSync;
            end
            `DCMG_ADDR_VCO: rData_r <= vcoIncr_r;
            default: rResp_r <= `DCMG_RESP_SLVERR;
        endcase
    end
    else if (rValid_r && s_axi_rready)
    begin
        rValid_r <= 1'b0;
        arReady_r <= 1'b1;
    end
end

assign s_axi_awready = awReady_r;
assign s_axi_wready = wReady_r;
assign s_axi_bvalid = bValid_r;
assign s_axi_bresp = bResp_r;
assign s_axi_arready = arReady_r;
assign s_axi_rvalid = rValid_r;
assign s_axi_rdata = rData_r;
assign s_axi_rresp = rResp_r;

endmodule
`default_nettype wire

// >>> dcmg_clock_gen_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dcmg_clock_gen_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Clock pins
    input wire logic pllSupplyStrap,
    input wire logic lockOrRateClockOut,
    // Write channels
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic wrTake;
    logic dualR;
    logic [1:0] modeR;
    logic [3:0] calmR;
    assign wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    // Settle count covers pin sync and output lag after any change
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            dualR <= 1'b0;
            modeR <= 2'h0;
            calmR <= 4'h0;
        end
        else
        begin
            if (wrTake && s_axi_awaddr == 4'h0 && s_axi_wstrb[0])
                dualR <= s_axi_wdata[0];
            modeR <= {pllSupplyStrap, dualR};
            if (wrTake || modeR != {pllSupplyStrap, dualR})
                calmR <= 4'h0;
            else if (calmR != 4'hF)
                calmR <= calmR + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence bothTaken;
        wrTake;
    endsequence
    sequence respLater;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    chk_write_answer:
    assert property (bothTaken |=> respLater) else $error("write response off time");
    chk_write_block:
    assert property (bothTaken |=> !s_axi_awready && !s_axi_wready) else $error("write not blocked");
    chk_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    chk_read_block:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read not blocked");
    chk_bad_addr:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC |=> s_axi_rresp == 2'h2)
        else $error("unmapped read not refused");
    chk_dual_low:
    assert property (calmR == 4'hF && dualR && !pllSupplyStrap |-> !lockOrRateClockOut)
        else $error("lock pin not low in dual mode");
endmodule
bind dcmg_clock_gen dcmg_clock_gen_assertions u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .pllSupplyStrap(pllSupplyStrap),
    .lockOrRateClockOut(lockOrRateClockOut), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// >>> dcmg_clock_gen_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcmg_regs.vh"
module dcmg_clock_gen_tb;
    localparam logic [33:0] FULL = 34'h3_FFFF_FFFF;
    logic clk_sys, sys_rst, pllSupplyStrap, sampleRateClockIn, dataRateClockIn, lockOrRateClockOut;
    logic [31:0] loopFilterNode, s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [33:0] rdQ[$], maskQ[$];
    logic [1:0] wrQ[$];
    int n_mismatch = 0, total_checks = 0, cycles = 0;
    dcmg_clock_gen u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .pllSupplyStrap(pllSupplyStrap),
        .sampleRateClockIn(sampleRateClockIn), .dataRateClockIn(dataRateClockIn),
        .lockOrRateClockOut(lockOrRateClockOut), .loopFilterNode(loopFilterNode),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    dcmg_clk_src u_src (.rateClkIn(lockOrRateClockOut), .sampleClk(sampleRateClockIn),
        .refClk(dataRateClockIn));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
        wrQ.push_back(resp);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        fork
            begin
                do @(posedge clk_sys); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge clk_sys); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
            end
        join
        s_axi_bready <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    // Ready is raised after the take so it never toggles twice in one step
    task automatic rd(input logic [3:0] a, input logic [33:0] e, input logic [33:0] m);
        rdQ.push_back(e);
        maskQ.push_back(m);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    // Sample clock is 8 system cycles, so the divided period is exact
    task automatic period(input int cyc);
        realtime t0;
        repeat (2) @(posedge lockOrRateClockOut);
        t0 = $realtime;
        @(posedge lockOrRateClockOut);
        check(34'(int'($realtime - t0)), 34'(cyc * 5));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys)
    begin
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata} & maskQ.pop_front(), rdQ.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            check(34'(s_axi_bresp), 34'(wrQ.pop_front()));
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial
    begin
        logic [31:0] r;
        logic [1:0] sel;
        void'($urandom(32'hA336));
        {sys_rst, pllSupplyStrap} = 2'b10;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        rd(`DCMG_ADDR_CTRL, 34'h0, FULL);
        rd(`DCMG_ADDR_STATUS, 34'h0, FULL);
        rd(`DCMG_ADDR_VCO, 34'h1000_0000, FULL);
        rd(4'hC, 34'h2_0000_0000, 34'h3_0000_0000);
        r = $urandom;
        wr(4'hC, r, 2'h2);
        wr(`DCMG_ADDR_STATUS, r, 2'h0);
        rd(`DCMG_ADDR_STATUS, 34'h0, FULL);
        for (int i = 0; i < 4; i++)
        begin
            sel = 2'(i);
            r = $urandom;
            wr(`DCMG_ADDR_CTRL, {r[31:3], sel, 1'b0}, 2'h0);
            rd(`DCMG_ADDR_CTRL, {29'h0, r[4:3], sel, 1'b0}, 34'h3_0000_001F);
            period(16 << i);
        end
        rd(`DCMG_ADDR_VCO, 34'h1000_0000, FULL);
        for (int i = 0; i < 4; i++)
        begin
            r = $urandom;
            wr(`DCMG_ADDR_CTRL, {r[31:3], 2'(i), 1'b1}, 2'h0);
            rd(`DCMG_ADDR_STATUS, 34'h2, FULL);
            repeat (40) @(posedge clk_sys);
            check(34'(lockOrRateClockOut), 34'h0);
        end
        // Dual bit stays set so strap must win over it
        pllSupplyStrap <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rd(`DCMG_ADDR_STATUS, 34'h9, 34'h3_FFFF_FFFB);
        repeat (200) @(posedge clk_sys);
        // Reference runs far faster than feedback, so the loop must speed up
        check(34'(loopFilterNode > `DCMG_VCO_INCR_RST), 34'h1);
        check(34'(lockOrRateClockOut), 34'h0);
        pllSupplyStrap <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rd(`DCMG_ADDR_STATUS, 34'h2, FULL);
        wr(`DCMG_ADDR_CTRL, 32'h0, 2'h0);
        rd(`DCMG_ADDR_STATUS, 34'h0, FULL);
        rd(`DCMG_ADDR_VCO, 34'h1000_0000, FULL);
        period(16);
        check(34'(u_src.words > 0), 34'h1);
        stop_test();
    end
endmodule
`default_nettype wire

// >>> dcmg_pfd.v
`timescale 1ns/1ps
`default_nettype none
`include "dcmg_regs.vh"

module dcmg_pfd (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // Edge events
    input wire enable,
    input wire refEdge,
    input wire fbEdge,
    // Steering and lock
    output reg pumpUp,
    output reg pumpDown,
    output reg locked
);

localparam ST_IDLE = 2'd0;
localparam ST_UP = 2'd1;
localparam ST_DOWN = 2'd2;

reg [1:0] state_r;
reg [1:0] state_nxt;
reg [7:0] errCnt_r;
reg [7:0] goodCnt_r;
wire closing;

////////////////////////////////////////////////////////////////////////////////
// Three-state detector: reference leads sets up, feedback leads sets down
always @*
begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE:
        begin
            if (refEdge && !fbEdge)
                state_nxt = ST_UP;
            else if (fbEdge && !refEdge)
                state_nxt = ST_DOWN;
        end
        ST_UP:
        begin
            if (fbEdge)
                state_nxt = ST_IDLE;
        end
        ST_DOWN:
        begin
            if (refEdge)
                state_nxt = ST_IDLE;
        end
        default:
            state_nxt = ST_IDLE;
    endcase
end

// One comparison ends here, or both edges met at once
assign closing = (state_r != ST_IDLE && state_nxt == ST_IDLE) ||
                 (state_r == ST_IDLE && refEdge && fbEdge);

always @(posedge clk_sys)
begin
    if (sys_rst || !enable)
    begin
        state_r <= ST_IDLE;
        errCnt_r <= 8'h00;
        goodCnt_r <= 8'h00;
        pumpUp <= 1'b0;
        pumpDown <= 1'b0;
        locked <= 1'b0;
    end
    else
    begin
        state_r <= state_nxt;
        pumpUp <= (state_nxt == ST_UP);
        pumpDown <= (state_nxt == ST_DOWN);
        if (closing)
        begin
            errCnt_r <= 8'h00;
            // Lock needs a run of small errors, one bad compare drops it
            if (errCnt_r <= `DCMG_LOCK_TOL)
            begin
                if (goodCnt_r != `DCMG_LOCK_COUNT)
                    goodCnt_r <= goodCnt_r + 8'h01;
            end
            else
                goodCnt_r <= 8'h00;
        end
        else if (state_r != ST_IDLE && errCnt_r != 8'hFF)
            errCnt_r <= errCnt_r + 8'h01;
        locked <= (goodCnt_r == `DCMG_LOCK_COUNT);
    end
end

endmodule
`default_nettype wire

// >>> dcmg_regs.vh
`ifndef DCMG_REGS_VH
`define DCMG_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets (byte addresses)
`define DCMG_ADDR_CTRL 4'h0
`define DCMG_ADDR_STATUS 4'h4
`define DCMG_ADDR_VCO 4'h8

// Control word fields
`define DCMG_CTRL_DUAL_BIT 0
`define DCMG_CTRL_SEL_LSB 1
`define DCMG_CTRL_DIV_LSB 3
`define DCMG_CTRL_RST 5'h00

// Status word fields
`define DCMG_STAT_MODE_LSB 0
`define DCMG_STAT_LOCK_BIT 2
`define DCMG_STAT_STRAP_BIT 3

// Clock mode codes
`define DCMG_MODE_EXT 2'h0
`define DCMG_MODE_PLL 2'h1
`define DCMG_MODE_DUAL 2'h2

// Bus responses
`define DCMG_RESP_OKAY 2'h0
`define DCMG_RESP_SLVERR 2'h2

////////////////////////////////////////////////////////////////////////////////
// Loop and lock constants
`define DCMG_VCO_INCR_RST 32'h1000_0000
`define DCMG_VCO_GAIN 32'h0000_1000
`define DCMG_VCO_INCR_MAX 32'hF000_0000
`define DCMG_LOCK_TOL 8'h04
`define DCMG_LOCK_COUNT 8'h10

`endif

// >>> dcmg_sync.v
`timescale 1ns/1ps
`default_nettype none

module dcmg_sync #(
    parameter WIDTH = 3
) (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // Asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

////////////////////////////////////////////////////////////////////////////////
// First stage feeds only the second stage
reg [WIDTH-1:0] meta_r;
reg [WIDTH-1:0] sync_r;

always @(posedge clk_sys)
begin
    if (sys_rst)
    begin
        meta_r <= {WIDTH{1'b0}};
        sync_r <= {WIDTH{1'b0}};
    end
    else
    begin
        meta_r <= asyncIn;
        sync_r <= meta_r;
    end
end

assign syncOut = sync_r;

endmodule
`default_nettype wire
